// *** pct_regs.svh ***
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH

// ----------------------------------------
// panel geometry and timing
// ----------------------------------------
`define PCT_H_ACTIVE 11'h0280
`define PCT_H_SYNC_START 11'h0290
`define PCT_H_SYNC_END 11'h02F0
`define PCT_H_TOTAL 11'h031F
`define PCT_V_ACTIVE 10'h01E0
`define PCT_V_SYNC_START 10'h01EA
`define PCT_V_SYNC_END 10'h01EC
`define PCT_V_TOTAL 10'h020C
`define PCT_FIFO_DEPTH 8
`define PCT_SLOW_DIV 4'h3
`define PCT_SEQ_STEPS 8'h40
`define PCT_STRAP_WAIT 2'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define PCT_R_HI 23
`define PCT_R_LO 16
`define PCT_DAC_W 6
`define PCT_TV_NTSC 2'h0
`endif

// *** pct_pkg.sv ***
package pct_pkg;
	typedef enum logic [1:0] {pct_tft24, pct_tft18, pct_tft12, pct_tft9} pct_width_type;
	typedef enum logic [1:0] {pct_tft, pct_stn16, pct_stn_dclk, pct_mono} pct_panel_type;
	typedef struct packed {
		logic [23:0] rgb;
		logic [5:0] dac_r;
		logic [5:0] dac_g;
		logic [5:0] dac_b;
		logic [7:0] stn_upper;
	} pct_pixel_type;
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic composite_sync_out;
		logic line_clk;
		logic frame_start;
		logic data_enable;
	} pct_sync_type;
endpackage

// *** pct_fifo.sv ***
`timescale 1ns/100ps
module pct_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] pct_inc(input logic [AW-1:0] p);
		pct_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push = in_valid_i && in_ready_o && ce_i;
	assign pop = out_valid_o && out_ready_i && ce_i;
	assign out_data_o = mem_q[rd_q];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= pct_inc(wr_q);
			end
			if (pop) begin
				rd_q <= pct_inc(rd_q);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // pct_fifo

// *** pct_top.sv ***
`timescale 1ns/100ps
`include "pct_regs.svh"
module pct_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// pixel stream in
	input wire logic pix_valid_i,
	output logic pix_ready_o,
	input wire pct_pkg::pct_pixel_type pix_i,
	// configuration
	input wire pct_pkg::pct_panel_type panel_type_i,
	input wire pct_pkg::pct_width_type panel_width_i,
	input wire logic hsync_pol_i,
	input wire logic vsync_pol_i,
	input wire logic [1:0] tv_format_field_i,
	input wire logic shared_pin_function_bit_i,
	input wire logic encoder_power_i,
	input wire logic ext_dac_access_i,
	input wire logic pci_mode_i,
	input wire logic panel_power_req_i,
	// pins in
	input wire logic slow_suspend_clock_i,
	input wire logic external_clock_strap_i,
	input wire logic synth_reference_in_i,
	// panel pins
	output logic [23:0] panel_data_o,
	output logic panel_data_line_22_o,
	output logic panel_data_line_23_o,
	output logic panel_data_enable_out_o,
	output logic panel_pixel_shift_clock_o,
	output logic panel_frame_start_o,
	output logic panel_line_clock_o,
	// crt and encoder pins
	output logic [5:0] dac_red_o,
	output logic [5:0] dac_green_o,
	output logic [5:0] dac_blue_o,
	output logic hsync_o,
	output logic vsync_o,
	output logic composite_sync_out_o,
	output logic tv_format_select_out_o,
	output logic shared_select_out_o,
	// status
	output logic external_video_clock_sel_o,
	output logic external_video_clock_in_o,
	output logic panel_power_on_o,
	output logic refresh_tick_o
);
	import pct_pkg::*;

	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_b;
	logic [1:0] slow_sync_q;
	logic [1:0] strap_sync_q;
	logic [1:0] ref_sync_q;
	logic slow_last_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_q[1];

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			slow_sync_q <= 2'h0;
			strap_sync_q <= 2'h0;
			ref_sync_q <= 2'h0;
		end else if (ce_i) begin
			slow_sync_q <= {slow_sync_q[0], slow_suspend_clock_i};
			strap_sync_q <= {strap_sync_q[0], external_clock_strap_i};
			ref_sync_q <= {ref_sync_q[0], synth_reference_in_i};
		end
	end

	// ----------------------------------------
	// external clock strap, caught after reset
	// ----------------------------------------
	logic strap_taken_q;
	logic [1:0] strap_wait_q;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			strap_taken_q <= 1'b0;
			strap_wait_q <= 2'h0;
			external_video_clock_sel_o <= 1'b0;
			external_video_clock_in_o <= 1'b0;
		end else if (ce_i) begin
			// wait for the synchroniser to fill before sampling the strap
			if (strap_wait_q != `PCT_STRAP_WAIT) begin
				strap_wait_q <= strap_wait_q + 2'h1;
			end else if (!strap_taken_q) begin
				strap_taken_q <= 1'b1;
				external_video_clock_sel_o <= strap_sync_q[1];
			end
			// reference pin doubles as test video clock; 14.318 MHz otherwise
			external_video_clock_in_o <= external_video_clock_sel_o & ref_sync_q[1];
		end
	end

	// ----------------------------------------
	// slow clock: refresh and power sequencing
	// ----------------------------------------
	logic slow_edge;
	logic [3:0] slow_div_q;
	logic [7:0] seq_cnt_q;
	assign slow_edge = slow_sync_q[1] & ~slow_last_q;

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			slow_last_q <= 1'b0;
			slow_div_q <= 4'h0;
			refresh_tick_o <= 1'b0;
		end else if (ce_i) begin
			slow_last_q <= slow_sync_q[1];
			refresh_tick_o <= 1'b0;
			if (slow_edge) begin
				if (slow_div_q == `PCT_SLOW_DIV) begin
					slow_div_q <= 4'h0;
					refresh_tick_o <= 1'b1;
				end else begin
					slow_div_q <= slow_div_q + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			seq_cnt_q <= 8'h00;
			panel_power_on_o <= 1'b0;
		end else if (ce_i) begin
			// power steps only on slow edges so timing is crystal-independent
			if (panel_power_req_i != panel_power_on_o) begin
				if (slow_edge) begin
					if (seq_cnt_q == `PCT_SEQ_STEPS) begin
						seq_cnt_q <= 8'h00;
						panel_power_on_o <= panel_power_req_i;
					end else begin
						seq_cnt_q <= seq_cnt_q + 8'h01;
					end
				end
			end else begin
				seq_cnt_q <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// pixel fifo
	// ----------------------------------------
	logic fifo_valid;
	logic fifo_ready;
	pct_pixel_type fifo_pix;
	logic active;

	// eight words ride out short gaps in the pixel source
	pct_fifo #(
		.WIDTH($bits(pct_pixel_type)),
		.DEPTH(`PCT_FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b),
		.ce_i(ce_i),
		.in_valid_i(pix_valid_i),
		.in_ready_o(pix_ready_o),
		.in_data_i(pix_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_ready),
		.out_data_o(fifo_pix)
	);

	// ----------------------------------------
	// raster timing
	// ----------------------------------------
	typedef enum logic [1:0] {pct_idle, pct_run} pct_state_type;
	pct_state_type state_q;
	logic [10:0] hcnt_q;
	logic [9:0] vcnt_q;
	logic shift_q;
	logic pix_phase;

	// two clocks per pixel: low half loads data, high half strobes it
	assign pix_phase = shift_q;
	assign active = (hcnt_q < `PCT_H_ACTIVE) && (vcnt_q < `PCT_V_ACTIVE);
	// stalls the raster when the fifo runs dry during active video
	assign fifo_ready = (state_q == pct_run) && active && !pix_phase;

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= pct_idle;
			hcnt_q <= 11'h000;
			vcnt_q <= 10'h000;
			shift_q <= 1'b0;
		end else if (ce_i) begin
			case (state_q)
				pct_idle: begin
					if (fifo_valid) begin
						state_q <= pct_run;
					end
				end
				pct_run: begin
					if (!active || pix_phase || fifo_valid) begin
						shift_q <= ~shift_q;
						if (pix_phase) begin
							if (hcnt_q == `PCT_H_TOTAL) begin
								hcnt_q <= 11'h000;
								vcnt_q <= (vcnt_q == `PCT_V_TOTAL) ? 10'h000 : vcnt_q + 10'h001;
							end else begin
								hcnt_q <= hcnt_q + 11'h001;
							end
						end
					end
				end
				default: state_q <= pct_idle;
			endcase
		end
	end

	// ----------------------------------------
	// sync generation
	// ----------------------------------------
	function automatic logic pct_in_range(input logic [10:0] v, input logic [10:0] lo,
		input logic [10:0] hi);
		pct_in_range = (v >= lo) && (v < hi);
	endfunction

	// one helper so both syncs invert alike
	function automatic logic pct_polar(input logic level, input logic invert);
		pct_polar = level ^ invert;
	endfunction

	pct_sync_type sync_d;
	always_comb begin
		sync_d.hsync = pct_in_range(hcnt_q, `PCT_H_SYNC_START, `PCT_H_SYNC_END);
		sync_d.vsync = pct_in_range({1'b0, vcnt_q}, {1'b0, `PCT_V_SYNC_START},
			{1'b0, `PCT_V_SYNC_END});
		sync_d.composite_sync_out = sync_d.hsync ^ sync_d.vsync;
		sync_d.line_clk = sync_d.hsync && (hcnt_q == `PCT_H_SYNC_START) && pix_phase;
		sync_d.frame_start = (vcnt_q == 10'h000) && sync_d.line_clk;
		sync_d.data_enable = active && (state_q == pct_run);
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			hsync_o <= 1'b0;
			vsync_o <= 1'b0;
			composite_sync_out_o <= 1'b0;
			panel_line_clock_o <= 1'b0;
			panel_frame_start_o <= 1'b0;
			panel_pixel_shift_clock_o <= 1'b0;
			panel_data_enable_out_o <= 1'b0;
		end else if (ce_i) begin
			hsync_o <= pct_polar(sync_d.hsync, hsync_pol_i);
			vsync_o <= pct_polar(sync_d.vsync, vsync_pol_i);
			composite_sync_out_o <= sync_d.composite_sync_out;
			panel_line_clock_o <= sync_d.line_clk;
			panel_frame_start_o <= sync_d.frame_start;
			panel_pixel_shift_clock_o <= pix_phase && sync_d.data_enable;
			// dual-clock stn: second shift clock runs in opposite phase
			panel_data_enable_out_o <= (panel_type_i == pct_stn_dclk) ?
				(!pix_phase && sync_d.data_enable) : sync_d.data_enable;
		end
	end

	// ----------------------------------------
	// panel data and dac
	// ----------------------------------------
	// mono panels leave lines 22 and 23 low
	logic [1:0] line_pair;
	always_comb begin
		line_pair = 2'h0;
		if (panel_type_i == pct_tft) begin
			case (panel_width_i)
				pct_tft24: line_pair = {fifo_pix.rgb[23], fifo_pix.rgb[22]};
				pct_tft18: line_pair = {fifo_pix.rgb[21], fifo_pix.rgb[20]};
				pct_tft12: line_pair = {fifo_pix.rgb[19], fifo_pix.rgb[18]};
				pct_tft9: line_pair = {fifo_pix.rgb[18], fifo_pix.rgb[17]};
				default: line_pair = 2'h0;
			endcase
		end else if (panel_type_i != pct_mono) begin
			line_pair = {fifo_pix.stn_upper[3], fifo_pix.stn_upper[2]};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			panel_data_o <= 24'h00_0000;
			panel_data_line_22_o <= 1'b0;
			panel_data_line_23_o <= 1'b0;
		end else if (ce_i) begin
			if (fifo_ready && fifo_valid) begin
				panel_data_o <= {line_pair, fifo_pix.rgb[`PCT_R_HI-2:0]};
				panel_data_line_22_o <= line_pair[0];
				panel_data_line_23_o <= line_pair[1];
			end
		end
	end

	// dac follows the same drain strobe as the panel bus
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			dac_red_o <= 6'h00;
			dac_green_o <= 6'h00;
			dac_blue_o <= 6'h00;
		end else if (ce_i) begin
			if (fifo_ready && fifo_valid) begin
				dac_red_o <= fifo_pix.dac_r;
				dac_green_o <= fifo_pix.dac_g;
				dac_blue_o <= fifo_pix.dac_b;
			end else if (!active) begin
				// blank the dacs outside active video
				dac_red_o <= 6'h00;
				dac_green_o <= 6'h00;
				dac_blue_o <= 6'h00;
			end
		end
	end

	// ----------------------------------------
	// encoder pins
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			tv_format_select_out_o <= 1'b0;
			shared_select_out_o <= 1'b0;
		end else if (ce_i) begin
			// any nonzero field selects pal; field read as a whole
			tv_format_select_out_o <= (tv_format_field_i != `PCT_TV_NTSC);
			if (!shared_pin_function_bit_i) begin
				shared_select_out_o <= encoder_power_i;
			end else begin
				// dac select is unsupported on pci, held low there
				shared_select_out_o <= ext_dac_access_i && !pci_mode_i;
			end
		end
	end
endmodule // pct_top

// *** pct_top_checker.sv ***
`timescale 1ns/100ps
module pct_top_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// config
	input wire logic hsync_pol_i,
	input wire logic vsync_pol_i,
	input wire logic [1:0] tv_format_field_i,
	input wire logic shared_pin_function_bit_i,
	input wire logic encoder_power_i,
	input wire logic ext_dac_access_i,
	input wire logic pci_mode_i,
	// pins
	input wire logic [23:0] panel_data_o,
	input wire logic panel_data_line_22_o,
	input wire logic panel_data_line_23_o,
	input wire logic panel_pixel_shift_clock_o,
	input wire logic panel_frame_start_o,
	input wire logic panel_line_clock_o,
	input wire logic hsync_o,
	input wire logic vsync_o,
	input wire logic composite_sync_out_o,
	input wire logic tv_format_select_out_o,
	input wire logic shared_select_out_o,
	input wire logic refresh_tick_o
);
	logic [2:0] cnt_q;
	logic rdy;
	default clocking cb @(posedge clk_i); endclocking
	// a frozen clock enable holds pulses high, so checks pause with it
	default disable iff (!rst_b_i || !ce_i);
	// outputs lag reset release, so wait out the sync stages
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) cnt_q <= 3'h0;
		else if (!rdy) cnt_q <= cnt_q + 3'h1;
	end
	assign rdy = cnt_q == 3'h7;
	sequence s_lc_quiet; !panel_line_clock_o [*8]; endsequence
	sequence s_tk_quiet; !refresh_tick_o [*8]; endsequence
	property p_l22; panel_data_line_22_o == panel_data_o[22]; endproperty
	a_l22: assert property (p_l22) else $error("line 22 off bus");
	property p_l23; panel_data_line_23_o == panel_data_o[23]; endproperty
	a_l23: assert property (p_l23) else $error("line 23 off bus");
	property p_shift; panel_pixel_shift_clock_o |=> !panel_pixel_shift_clock_o; endproperty
	a_shift: assert property (p_shift) else $error("shift clock too long");
	property p_frame; panel_frame_start_o |=> !panel_frame_start_o; endproperty
	a_frame: assert property (p_frame) else $error("frame pulse too long");
	property p_line; panel_line_clock_o |=> s_lc_quiet; endproperty
	a_line: assert property (p_line) else $error("line clock too close");
	property p_composite_sync_out;
		rdy && $stable(hsync_pol_i) && $stable(vsync_pol_i) |->
			composite_sync_out_o == (hsync_o ^ vsync_o ^ hsync_pol_i ^ vsync_pol_i);
	endproperty
	a_composite_sync_out: assert property (p_composite_sync_out) else $error("composite_sync_out wrong");
	property p_tv; rdy |-> tv_format_select_out_o == ($past(tv_format_field_i) != 2'h0); endproperty
	a_tv: assert property (p_tv) else $error("tv format wrong");
	property p_pwr;
		rdy && !$past(shared_pin_function_bit_i) |-> shared_select_out_o == $past(encoder_power_i);
	endproperty
	a_pwr: assert property (p_pwr) else $error("encoder power wrong");
	property p_xdac;
		rdy && $past(shared_pin_function_bit_i) |->
			shared_select_out_o == ($past(ext_dac_access_i) && !$past(pci_mode_i));
	endproperty
	a_xdac: assert property (p_xdac) else $error("dac select wrong");
	property p_tick; refresh_tick_o |=> s_tk_quiet; endproperty
	a_tick: assert property (p_tick) else $error("refresh ticks too close");
endmodule // pct_top_checker
bind pct_top pct_top_checker u_chk (.*);

// *** pct_panel_model.sv ***
`timescale 1ns/100ps
module pct_panel_model (
	// clock
	input wire logic clk_i,
	// panel strobes and data
	input wire logic shift_i,
	input wire logic [1:0] hi_i,
	input wire logic de_i,
	input wire logic [17:0] dac_i,
	input wire logic line_i,
	input wire logic frame_i
);
	logic [20:0] cap_q[$];
	logic shift_q = 1'b0;
	int frames = 0;
	int lines = 0;
	// data is latched where the shift clock rises, as a panel does
	always @(posedge clk_i) begin
		shift_q <= shift_i;
		if (shift_i && !shift_q) cap_q.push_back({de_i, hi_i, dac_i});
		if (frame_i) frames++;
		if (line_i) lines++;
	end
endmodule // pct_panel_model

// *** pct_top_tb.sv ***
`timescale 1ns/100ps
`include "pct_regs.svh"
module pct_top_tb;
	import pct_pkg::*;
	// ----
	// signals
	// ----
	logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, pix_valid_i = 1'b0, pix_ready_o;
	pct_pixel_type pix_i = '0;
	pct_panel_type panel_type_i = pct_tft;
	pct_width_type panel_width_i = pct_tft24;
	logic hsync_pol_i = 1'b0, vsync_pol_i = 1'b0, shared_pin_function_bit_i = 1'b0;
	logic [1:0] tv_format_field_i = 2'h0;
	logic encoder_power_i = 1'b0, ext_dac_access_i = 1'b0, pci_mode_i = 1'b0;
	logic panel_power_req_i = 1'b0, slow_suspend_clock_i = 1'b0;
	logic external_clock_strap_i = 1'b0, synth_reference_in_i = 1'b0;
	logic [23:0] panel_data_o;
	logic [5:0] dac_red_o, dac_green_o, dac_blue_o;
	logic panel_data_line_22_o, panel_data_line_23_o, panel_data_enable_out_o;
	logic panel_pixel_shift_clock_o, panel_frame_start_o, panel_line_clock_o;
	logic hsync_o, vsync_o, composite_sync_out_o, tv_format_select_out_o;
	logic shared_select_out_o, external_video_clock_sel_o, external_video_clock_in_o;
	logic panel_power_on_o, refresh_tick_o;
	logic [19:0] exp_q[$];
	logic [20:0] c;
	logic [7:0] n = 8'h00;
	logic feed = 1'b0, v, de_q = 1'b0, ck;
	int error_cnt = 0, check_count = 0, sr = 0, tk = 0, der = 0, refuse = 0;
	int p, h0, h1, s0, k0;
	pct_top u_dut (.*);
	pct_panel_model u_pnl (.clk_i(clk_i), .shift_i(panel_pixel_shift_clock_o),
		.hi_i({panel_data_line_23_o, panel_data_line_22_o}), .de_i(panel_data_enable_out_o),
		.dac_i({dac_red_o, dac_green_o, dac_blue_o}), .line_i(panel_line_clock_o),
		.frame_i(panel_frame_start_o));
	// ----
	// clocks
	// ----
	initial forever #20 clk_i = ~clk_i;
	initial forever #34.9 synth_reference_in_i = ~synth_reference_in_i;
	initial forever #320 slow_suspend_clock_i = ~slow_suspend_clock_i;
	always @(posedge slow_suspend_clock_i) sr++;
	// ----
	// pixel feeder and scoreboard
	// ----
	function automatic logic [1:0] fmap(pct_pixel_type x);
		int b;
		b = (panel_width_i == pct_tft9) ? 17 : 22 - 2 * int'(panel_width_i);
		fmap = 2'b00;
		if (panel_type_i == pct_tft) fmap = x.rgb[b +: 2];
		else if (panel_type_i != pct_mono) fmap = x.stn_upper[3:2];
	endfunction
	// valid held while refused, data only moves on acceptance
	always @(posedge clk_i) begin
		v = feed;
		tk += refresh_tick_o;
		der += panel_data_enable_out_o & ~de_q;
		de_q = panel_data_enable_out_o;
		refuse += pix_valid_i & ~pix_ready_o;
		if (pix_valid_i && pix_ready_o && ce_i) begin
			exp_q.push_back({fmap(pix_i), pix_i.dac_r, pix_i.dac_g, pix_i.dac_b});
			n = n + 8'h01;
		end
		#1 pix_valid_i = v;
		pix_i = {{3{n}} ^ 24'h5a_a55a, n[5:0], ~n[5:0], n[6:1], n ^ 8'h3c};
	end
	always @(negedge clk_i) while (u_pnl.cap_q.size() != 0) begin
		c = u_pnl.cap_q.pop_front();
		if (exp_q.size() == 0) chk("extra pixel", 1, 0);
		else begin
			chk("dac", c[17:0], exp_q[0][17:0]);
			chk("lines", c[19:18], exp_q[0][19:18]);
			if (panel_type_i != pct_stn_dclk) chk("enable", c[20], 1);
			void'(exp_q.pop_front());
		end
	end
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task fail(input string nm);
		chk(nm, 1, 0);
		results();
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task drain;
		feed = 0;
		cyc(2);
		for (int i = 0; i < 4000 && exp_q.size() != 0; i++) cyc(1);
		if (exp_q.size() != 0) fail("drain");
	endtask
	task run(input pct_panel_type t, input pct_width_type w, input int k);
		drain();
		panel_type_i = t;
		panel_width_i = w;
		cyc(2);
		feed = 1;
		cyc(k);
		drain();
	endtask
	task line(output int per, hi);
		per = 0;
		hi = 0;
		for (int i = 0; i < 5000 && !panel_line_clock_o; i++) cyc(1);
		do begin
			cyc(1);
			per++;
			hi += hsync_o;
		end while (!panel_line_clock_o && per < 5000);
		if (!panel_line_clock_o) fail("line clock");
	endtask
	task slow(input int k);
		s0 = sr;
		for (int i = 0; i < 2000 && sr - s0 < k; i++) cyc(1);
		if (sr - s0 < k) fail("slow clock");
	endtask
	task rst(input logic s);
		feed = 0;
		rst_b_i = 0;
		external_clock_strap_i = s;
		cyc(5);
		rst_b_i = 1;
		exp_q.delete();
		u_pnl.cap_q.delete();
		cyc(12);
		chk("strap", external_video_clock_sel_o, s);
	endtask
	// ----
	// sequence
	// ----
	initial begin
		rst(0);
		for (int f = 0; f < 4; f++) begin
			tv_format_field_i = f[1:0];
			cyc(2);
			chk("tv format", tv_format_select_out_o, f != 0);
		end
		for (int k = 0; k < 16; k++) begin
			{shared_pin_function_bit_i, encoder_power_i, ext_dac_access_i, pci_mode_i} = k[3:0];
			cyc(2);
			chk("shared pin", shared_select_out_o, k[3] ? k[1] & ~k[0] : k[2]);
		end
		for (int w = 0; w < 4; w++) run(pct_tft, pct_width_type'(w), 60);
		run(pct_stn16, pct_tft24, 60);
		run(pct_mono, pct_tft24, 60);
		der = 0;
		run(pct_stn_dclk, pct_tft24, 60);
		chk("second shift clock", der > 20, 1);
		chk("fifo refused", refuse > 0, 1);
		run(pct_tft, pct_tft24, 2);
		feed = 1;
		vsync_pol_i = 1;
		cyc(3);
		line(p, h0);
		chk("line period", p, 2 * (`PCT_H_TOTAL + 1));
		chk("vsync idle", vsync_o, 1);
		hsync_pol_i = 1;
		vsync_pol_i = 0;
		cyc(3);
		line(p, h1);
		chk("hsync sum", h0 + h1, p);
		chk("hsync narrow", h0 < h1, 1);
		chk("vsync idle", vsync_o, 0);
		chk("frame start", u_pnl.frames, 1);
		chk("line pulses", u_pnl.lines, 3);
		ce_i = 0;
		cyc(40);
		ce_i = 1;
		p = 40;
		do begin
			cyc(1);
			p++;
		end while (!panel_line_clock_o && p < 5000);
		chk("frozen line", p, 2 * (`PCT_H_TOTAL + 1) + 40);
		panel_power_req_i = 1;
		k0 = tk;
		slow(40);
		chk("refresh ticks", tk - k0 >= 9 && tk - k0 <= 11, 1);
		slow(20);
		chk("power early", panel_power_on_o, 0);
		slow(12);
		chk("power on", panel_power_on_o, 1);
		rst(1);
		p = 0;
		ck = external_video_clock_in_o;
		repeat (40) begin
			cyc(1);
			p += external_video_clock_in_o != ck;
			ck = external_video_clock_in_o;
		end
		chk("ext clock", p > 10, 1);
		rst(0);
		run(pct_tft, pct_tft24, 40);
		results();
	end
endmodule // pct_top_tb
